// ---- rtl/wide_access.sv ----
// byte access path to the 16-bit count, compare and capture registers
// assumes a timer core that presents its live words and accepts commits
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - wide registers reached as two byte accesses
// - one 8-bit holding register per timer
// - holding register shared by all wide registers
// - transfer happens only on low-byte access
// - low write commits holding plus byte
// - low read returns low, captures high
// - compare reads bypass the holding register
module wide_access (
   input  wire logic                      sys_clk,
   input  wire logic                      rst_n,
   input  wire wide_access_pkg::byte_req_t req,
   input  wire logic [15:0]               timer_count_value,
   input  wire logic [15:0]               capture_value_reg,
   input  wire logic [47:0]               compare_value_regs,
   output wide_access_pkg::word_commit_t  commit_r,
   output logic [7:0]                     rdata_r,
   output logic [7:0]                     hold_r
);
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic is_compare(input logic [2:0] sel);
      is_compare = (sel == wide_access_pkg::SEL_CMP_A) ||
                   (sel == wide_access_pkg::SEL_CMP_B) ||
                   (sel == wide_access_pkg::SEL_CMP_C);
   endfunction

   logic [15:0] word_sel;
   logic [7:0]  hold_q;
   logic        hold_load;
   logic [7:0]  hold_nxt;
   logic [7:0]  rdata_nxt;
   logic [15:0] cmp_word [3];

   // the three compare words are sliced alike
   for (genvar g = 0; g < 3; g++) begin : g_cmp
      assign cmp_word[g] = compare_value_regs[16*g +: 16];
   end

   // unknown selectors read as zero rather than alias a real register
   always_comb begin
      unique case (req.sel)
         wide_access_pkg::SEL_COUNT:   word_sel = timer_count_value;
         wide_access_pkg::SEL_CMP_A:   word_sel = cmp_word[0];
         wide_access_pkg::SEL_CMP_B:   word_sel = cmp_word[1];
         wide_access_pkg::SEL_CMP_C:   word_sel = cmp_word[2];
         wide_access_pkg::SEL_CAPTURE: word_sel = capture_value_reg;
         default:                      word_sel = wide_access_pkg::WORD_RST;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // holding register load: high writes and low reads of non-compare words
   always_comb begin
      hold_load = 1'b0;
      hold_nxt  = hold_q;
      if (req.wr && req.hi) begin
         hold_load = 1'b1;
         hold_nxt  = req.wdata;
      end else if (req.rd && !req.hi && !is_compare(req.sel)) begin
         hold_load = 1'b1;
         hold_nxt  = word_sel[15:8];
      end
   end

   // one instance for every wide register: no per-register copy
   wide_hold_byte u_hold (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .load      (hold_load),
      .load_data (hold_nxt),
      .hold_q    (hold_q)
   );

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         hold_r <= wide_access_pkg::HOLD_RST;
      end else begin
         hold_r <= hold_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // commit pulse; holding is not cleared so it can be reused
   // sel and data follow req every cycle; only valid marks a commit
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         commit_r <= '0;
      end else begin
         commit_r.valid <= req.wr && !req.hi;
         commit_r.sel   <= req.sel;
         commit_r.data  <= {hold_q, req.wdata};
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read data; byte ordering is the processor's duty
   // an interrupt access between the two bytes overwrites holding unseen
   always_comb begin
      rdata_nxt = rdata_r;
      if (req.rd) begin
         if (!req.hi) begin
            rdata_nxt = word_sel[7:0];
         end else if (is_compare(req.sel)) begin
            rdata_nxt = word_sel[15:8];
         end else begin
            rdata_nxt = hold_q;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         rdata_r <= wide_access_pkg::RDATA_RST;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // all checks sleep while rst_n is low
   sequence s_high_write;
      req.wr && req.hi;
   endsequence

   sequence s_low_write;
      req.wr && !req.hi;
   endsequence

   // low-byte reads of any non-compare selector, the ones that go through holding
   sequence s_low_read;
      req.rd && !req.hi && !req.wr && !is_compare(req.sel);
   endsequence

   sequence s_high_read;
      req.rd && req.hi && !req.wr && !is_compare(req.sel);
   endsequence

   a_low_write_commit: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_high_write ##1 (s_low_write and !req.rd) |=> commit_r.valid &&
      commit_r.data == {$past(req.wdata, 2), $past(req.wdata)})
      else $error("low write did not commit held high byte");

   a_commit_only_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
      commit_r.valid |-> $past(req.wr) && !$past(req.hi))
      else $error("commit without low-byte write");

   a_high_write_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (req.wr && req.hi) |=> hold_q == $past(req.wdata))
      else $error("high write not held");

   a_low_read_capture: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_low_read |=>
      rdata_r == $past(word_sel[7:0]) && hold_q == $past(word_sel[15:8]))
      else $error("low read did not capture high byte");

   a_cmp_bypass: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (req.rd && !req.wr && is_compare(req.sel)) |=>
      hold_q == $past(hold_q) && (!$past(req.hi) || rdata_r == $past(word_sel[15:8])))
      else $error("compare read touched holding register");

   a_hold_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (s_low_write and !req.rd) |=> hold_q == $past(hold_q))
      else $error("holding register lost after commit");

   a_high_read_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_high_read |=> rdata_r == $past(hold_q))
      else $error("high read not from holding register");

   a_shared_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (req.wr && req.hi && req.sel == wide_access_pkg::SEL_COUNT) ##1
      (s_low_write and (!req.rd && req.sel == wide_access_pkg::SEL_CAPTURE)) |=>
      commit_r.data[15:8] == $past(req.wdata, 2))
      else $error("holding register not shared");

   a_read_pair: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_low_read ##1 s_high_read |=> rdata_r == $past(word_sel[15:8], 2))
      else $error("high byte not from the low-read snapshot");

   a_low_write_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (s_low_write and !req.rd) |=> commit_r.valid)
      else $error("low write did not commit");

   a_high_no_commit: assert property (@(posedge sys_clk) disable iff (!rst_n)
      s_high_write |=> !commit_r.valid)
      else $error("high write committed");

   a_commit_target: assert property (@(posedge sys_clk) disable iff (!rst_n)
      commit_r.valid |-> commit_r.sel == $past(req.sel))
      else $error("commit went to the wrong register");

   a_hold_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (!req.wr && !req.rd) |=> hold_q == $past(hold_q))
      else $error("holding register changed without access");

   a_hold_mirror: assert property (@(posedge sys_clk) disable iff (!rst_n)
      hold_r == hold_q)
      else $error("holding copy differs from holding register");

   a_rdata_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
      !req.rd |=> $stable(rdata_r))
      else $error("read data changed without a read");

   a_cmp_low_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (req.rd && !req.hi && !req.wr && is_compare(req.sel)) |=>
      rdata_r == $past(word_sel[7:0]))
      else $error("compare low byte wrong");

   a_unknown_sel_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
      (req.rd && !req.hi && !req.wr && req.sel > wide_access_pkg::SEL_CAPTURE) |=>
      rdata_r == 8'h00 && hold_q == 8'h00)
      else $error("unknown register read not zero");
endmodule

// ---- rtl/wide_access_pkg.sv ----
// package for the timer wide-register byte access path
// assumes one clock, synchronous active-low reset, 8-bit processor bus
package wide_access_pkg;
   localparam int          BYTE_W      = 8;
   localparam int          WORD_W      = 16;
   localparam int          SEL_W       = 3;
   // register selector codes on the processor side
   localparam logic [2:0]  SEL_COUNT   = 3'h0;
   localparam logic [2:0]  SEL_CMP_A   = 3'h1;
   localparam logic [2:0]  SEL_CMP_B   = 3'h2;
   localparam logic [2:0]  SEL_CMP_C   = 3'h3;
   localparam logic [2:0]  SEL_CAPTURE = 3'h4;
   localparam logic [7:0]  HOLD_RST    = 8'h00;
   localparam logic [15:0] WORD_RST    = 16'h0000;
   localparam logic [7:0]  RDATA_RST   = 8'h00;

   // one byte access from the processor
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [2:0] sel;
      logic       hi;
      logic [7:0] wdata;
   } byte_req_t;

   // one 16-bit commit toward the timer core
   typedef struct packed {
      logic       valid;
      logic [2:0] sel;
      logic [15:0] data;
   } word_commit_t;
endpackage

// ---- rtl/wide_hold_byte.sv ----
// shared high-byte holding register of one wide timer
// assumes the parent decides when it loads and with what
`timescale 1ns/10ps
module wide_hold_byte (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       load,
   input  wire logic [7:0] load_data,
   output logic [7:0]      hold_q
);
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         hold_q <= wide_access_pkg::HOLD_RST;
      end else if (load) begin
         hold_q <= load_data;
      end
   end
endmodule

// ---- tb/cpu_model.sv ----
// processor core model issuing byte accesses to the wide registers
// assumes callers enter just after a rising edge of sys_clk
`timescale 1ns/10ps
module cpu_model (
   input  wire logic                          sys_clk,
   input  wire logic [7:0]                    rdata_r,
   output wide_access_pkg::byte_req_t         req
);
   initial req = '0;
   // one byte per access, held across one taking edge
   task automatic acc(input logic w, input logic [2:0] s, input logic h, input logic [7:0] d);
      req = '{w, !w, s, h, d};
      @(posedge sys_clk);
      #1;
   endtask
   // a released bus shows inverted data, never the stale byte
   task automatic idle();
      req = '{1'b0, 1'b0, req.sel, req.hi, ~req.wdata};
      @(posedge sys_clk);
      #1;
   endtask
   // low before high, never interleaved with another access
   task automatic rd16(input logic [2:0] s, output logic [15:0] v);
      acc(1'b0, s, 1'b0, 8'h00);
      v[7:0] = rdata_r;
      acc(1'b0, s, 1'b1, 8'h00);
      v[15:8] = rdata_r;
      idle();
   endtask
endmodule

// ---- tb/testbench.sv ----
// bench for the wide-register byte access path
// assumes cpu_model drives the bus and this module plays the timer core
`timescale 1ns/10ps
module testbench;
   logic                          sys_clk = 1'b0;
   logic                          rst_n = 1'b0;
   logic [15:0]                   cnt = 16'h0000;
   logic [15:0]                   cap = 16'h0000;
   logic [47:0]                   cmp = {16'hC33C, 16'hB22B, 16'hA11A};
   logic [15:0]                   v;
   wide_access_pkg::byte_req_t    req;
   wide_access_pkg::word_commit_t commit_r;
   logic [7:0]                    rdata_r;
   logic [7:0]                    hold_r;
   int                            num_errors = 0;
   int                            total_checks = 0;
   always #12.5 sys_clk = ~sys_clk;
   wide_access u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .req(req), .timer_count_value(cnt),
      .capture_value_reg(cap), .compare_value_regs(cmp), .commit_r(commit_r),
      .rdata_r(rdata_r), .hold_r(hold_r));
   cpu_model u_cpu (.sys_clk(sys_clk), .rdata_r(rdata_r), .req(req));
   task automatic check(input string what, input logic [19:0] seen, input logic [19:0] exp);
      total_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_write();
      u_cpu.acc(1'b1, wide_access_pkg::SEL_COUNT, 1'b1, 8'h01);
      check("hold", hold_r, 8'h01);
      check("valid", commit_r.valid, 1'b0);
      u_cpu.acc(1'b1, wide_access_pkg::SEL_COUNT, 1'b0, 8'hFF);
      check("commit", commit_r, {1'b1, wide_access_pkg::SEL_COUNT, 16'h01FF});
      u_cpu.idle();
      check("valid", commit_r.valid, 1'b0);
      u_cpu.acc(1'b1, wide_access_pkg::SEL_COUNT, 1'b1, 8'h5A);
      u_cpu.acc(1'b1, wide_access_pkg::SEL_CAPTURE, 1'b0, 8'h77);
      check("commit", commit_r, {1'b1, wide_access_pkg::SEL_CAPTURE, 16'h5A77});
      u_cpu.idle();
      $display("write done");
   endtask
   // live count moves between the two reads; high half must not follow
   task automatic t_read();
      cnt = 16'hA55A;
      u_cpu.acc(1'b0, wide_access_pkg::SEL_COUNT, 1'b0, 8'h00);
      check("rd low", rdata_r, 8'h5A);
      check("hold", hold_r, 8'hA5);
      cnt = 16'h1234;
      u_cpu.acc(1'b0, wide_access_pkg::SEL_COUNT, 1'b1, 8'h00);
      check("rd high", rdata_r, 8'hA5);
      cap = 16'hBEEF;
      u_cpu.acc(1'b0, wide_access_pkg::SEL_CAPTURE, 1'b0, 8'h00);
      check("cap low", rdata_r, 8'hEF);
      u_cpu.acc(1'b0, wide_access_pkg::SEL_COUNT, 1'b1, 8'h00);
      check("shared", rdata_r, 8'hBE);
      u_cpu.idle();
      $display("read done");
   endtask
   task automatic t_cmp();
      for (int i = 0; i < 3; i++) begin
         u_cpu.rd16(wide_access_pkg::SEL_CMP_A + 3'(i), v);
         check("cmp", v, cmp[16*i +: 16]);
         check("hold", hold_r, 8'hBE);
      end
      $display("compare done");
   endtask
   task automatic t_reuse();
      u_cpu.acc(1'b0, 3'h5, 1'b0, 8'h00);
      check("unknown", {rdata_r, hold_r}, 16'h0000);
      u_cpu.acc(1'b1, wide_access_pkg::SEL_CMP_A, 1'b1, 8'h3C);
      u_cpu.acc(1'b1, wide_access_pkg::SEL_CMP_A, 1'b0, 8'h11);
      check("commit", commit_r, {1'b1, wide_access_pkg::SEL_CMP_A, 16'h3C11});
      u_cpu.acc(1'b1, wide_access_pkg::SEL_CMP_B, 1'b0, 8'h22);
      check("commit", commit_r, {1'b1, wide_access_pkg::SEL_CMP_B, 16'h3C22});
      u_cpu.idle();
      $display("reuse done");
   endtask
   // reset mid-run must clear holding as well as the visible copies
   task automatic t_reset();
      rst_n = 1'b0;
      u_cpu.idle();
      u_cpu.idle();
      rst_n = 1'b1;
      check("reset", {4'h0, rdata_r, hold_r}, 20'h00000);
      check("reset", commit_r, 20'h00000);
      u_cpu.acc(1'b0, wide_access_pkg::SEL_COUNT, 1'b1, 8'h00);
      check("rd high", rdata_r, 8'h00);
      u_cpu.idle();
      $display("reset done");
   endtask
   initial begin
      repeat (3) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
      check("reset", {4'h0, rdata_r, hold_r}, 20'h00000);
      check("reset", commit_r, 20'h00000);
      t_write();
      t_read();
      t_cmp();
      t_reuse();
      t_reset();
      end_of_test();
   end
   // run needs well under 200 cycles
   initial begin
      #20000;
      num_errors++;
      end_of_test();
   end
endmodule
